// File: hdl/uart_pkg.sv
package uart_pkg;
	// register offsets
	localparam logic [2:0] OFS_CTRL = 3'h0;
	localparam logic [2:0] OFS_TXDATA = 3'h1;
	localparam logic [2:0] OFS_PARAM1 = 3'h2;
	localparam logic [2:0] OFS_RXDATA = 3'h3;
	localparam logic [2:0] OFS_STATH = 3'h4;
	localparam logic [2:0] OFS_IRQ_STAT = 3'h5;
	localparam logic [2:0] OFS_IRQ_CLR = 3'h6;
	localparam logic [2:0] OFS_IRQ_EN = 3'h7;
	// control register fields
	localparam int C_STOP_SEL = 0;
	localparam int C_STOP_CHK = 2;
	localparam int C_ADDR = 3;
	localparam int C_WAKE = 4;
	localparam int C_SLEEP_EN = 5;
	localparam int C_T1 = 6;
	localparam int C_LAST = 7;
	localparam int C_BRK = 8;
	localparam logic [8:0] CTRL_RST = 9'h000;
	// status high register fields
	localparam int S_RXFULL = 0;
	localparam int S_BUSY = 1;
	localparam int S_FRAME_ERR = 2;
	localparam int S_OVERRUN = 3;
	localparam int S_TX_WR_ERR = 7;
	// interrupt bits
	localparam int I_RX = 0;
	localparam int I_FRAME = 1;
	localparam int I_OVERRUN = 2;
	localparam int I_WAIT = 3;
	localparam int I_WAKE = 4;
	localparam int IRQ_W = 5;
	localparam logic [4:0] IRQ_RST = 5'h00;
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BAUD_HZ = 1_250_000;
	localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
	localparam int BRK_BITS = 13;
endpackage

// File: hdl/uart_stop_break_wake.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - stop select 2 sends two stop bits and checks both on receive when the stop check bit is 0.
// - stop select 3 sends two stop bits, checks only the first.
// - char arriving with receive buffer full sets overrun, is discarded.
// - status high bit 7 is transmit write error, one clear write removes it.
// - address mode, parameter write with break bit set sends break then value.
// - break request bit self-clears once the break has been sent.
// - smart-card T=1 wait-time flag only after a char marked last.
module uart_stop_break_wake #(
	parameter int BIT_CYC = uart_pkg::BIT_CYC,
	parameter int BRK_BITS = uart_pkg::BRK_BITS
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [2:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic rxd_in,
	output logic txd_out,
	input wire logic sleep_in,
	output logic wake_out,
	output logic irq_out
);
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01, TX_BRK = 6'h02, TX_MARK = 6'h04,
		TX_START = 6'h08, TX_DATA = 6'h10, TX_STOP = 6'h20
	} tx_st_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
		RX_STOP1 = 5'h08, RX_STOP2 = 5'h10
	} rx_st_t;

	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) rst_sync_r <= 2'h0;
		else rst_sync_r <= {rst_sync_r[0], 1'h1};
	end
	assign rst_n = rst_sync_r[1];

	logic [8:0] ctrl_r;
	logic [4:0] irq_stat_r, irq_en_r, irq_set;
	logic [7:0] tx_buf_r, tx_sh_r, rx_data_r, rx_sh_r;
	logic tx_pend_r, tx_brk_pend_r, tx_last_r, tx_wr_err_r;
	logic frame_err_r, overrun_r;
	logic rx_full_r, rx_bad_r, tx_done, rx_done;
	logic [15:0] tx_cyc_r, rx_cyc_r;
	logic [3:0] tx_bits_r, rx_bits_r;
	tx_st_t tx_st_r;
	rx_st_t rx_st_r;
	logic wr_ctrl, wr_tx, wr_param, rd_rx, tx_tick, rx_tick, go, brk_req;
	logic [2:0] rx_sync_r;
	logic rx_lvl_r, rx_lvl_d_r, wake_r;

	assign wr_ctrl = wr_in && addr_in == uart_pkg::OFS_CTRL;
	assign wr_tx = wr_in && addr_in == uart_pkg::OFS_TXDATA;
	assign wr_param = wr_in && addr_in == uart_pkg::OFS_PARAM1;
	assign rd_rx = rd_in && addr_in == uart_pkg::OFS_RXDATA;
	assign brk_req = ctrl_r[uart_pkg::C_BRK];

	// control; break bit is set by software, cleared by hardware only
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= uart_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r[7:0] <= wdata_in[7:0];
				if (wdata_in[uart_pkg::C_BRK])
					ctrl_r[uart_pkg::C_BRK] <= 1'h1;
			end
			if (tx_st_r == TX_BRK && tx_tick && tx_bits_r == 4'(BRK_BITS - 1))
				ctrl_r[uart_pkg::C_BRK] <= 1'h0;
		end
	end

	// transmit holding register
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_pend_r <= 1'h0;
			tx_brk_pend_r <= 1'h0;
			tx_buf_r <= 8'h00;
			tx_wr_err_r <= 1'h0;
		end else begin
			if (go) tx_pend_r <= 1'h0;
			if ((wr_tx || wr_param) && !tx_pend_r) begin
				tx_pend_r <= 1'h1;
				tx_buf_r <= wdata_in[7:0];
				tx_brk_pend_r <= wr_param && brk_req &&
					ctrl_r[uart_pkg::C_ADDR];
			end
			if (wr_in && addr_in == uart_pkg::OFS_STATH &&
				wdata_in[uart_pkg::S_TX_WR_ERR])
				tx_wr_err_r <= 1'h0;
			if ((wr_tx || wr_param) && tx_pend_r)
				tx_wr_err_r <= 1'h1;
		end
	end

	assign go = tx_st_r == TX_IDLE && tx_pend_r;
	assign tx_tick = tx_cyc_r == 16'(BIT_CYC - 1);

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r <= TX_IDLE;
			tx_cyc_r <= 16'h0000;
			tx_bits_r <= 4'h0;
			tx_sh_r <= 8'h00;
			tx_last_r <= 1'h0;
		end else begin
			tx_cyc_r <= (tx_tick || tx_st_r == TX_IDLE) ? 16'h0000 :
				tx_cyc_r + 16'h0001;
			unique case (tx_st_r)
			TX_IDLE: begin
				tx_bits_r <= 4'h0;
				if (go) begin
					tx_sh_r <= tx_buf_r;
					tx_last_r <= ctrl_r[uart_pkg::C_LAST];
					tx_st_r <= tx_brk_pend_r ? TX_BRK : TX_START;
				end
			end
			TX_BRK: if (tx_tick) begin
				tx_bits_r <= tx_bits_r + 4'h1;
				if (tx_bits_r == 4'(BRK_BITS - 1)) tx_st_r <= TX_MARK;
			end
			TX_MARK: if (tx_tick) tx_st_r <= TX_START;
			TX_START: if (tx_tick) begin
				tx_st_r <= TX_DATA;
				tx_bits_r <= 4'h0;
			end
			TX_DATA: if (tx_tick) begin
				tx_sh_r <= {1'h0, tx_sh_r[7:1]};
				tx_bits_r <= tx_bits_r + 4'h1;
				if (tx_bits_r == 4'h7) begin
					tx_st_r <= TX_STOP;
					tx_bits_r <= 4'h0;
				end
			end
			TX_STOP: if (tx_tick) begin
				tx_bits_r <= tx_bits_r + 4'h1;
				// select 2 or 3 sends a second stop bit
				if (!ctrl_r[uart_pkg::C_STOP_SEL + 1] || tx_bits_r == 4'h1)
					tx_st_r <= TX_IDLE;
			end
			endcase
		end
	end

	assign tx_done = tx_st_r == TX_STOP && tx_tick &&
		(!ctrl_r[uart_pkg::C_STOP_SEL + 1] || tx_bits_r == 4'h1);

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) txd_out <= 1'h1;
		else txd_out <= !(tx_st_r == TX_BRK || tx_st_r == TX_START ||
			(tx_st_r == TX_DATA && !tx_sh_r[0]));
	end

	// line input: three stages, change accepted when last two agree
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_sync_r <= 3'h7;
			rx_lvl_r <= 1'h1;
			rx_lvl_d_r <= 1'h1;
		end else begin
			rx_sync_r <= {rx_sync_r[1:0], rxd_in};
			if (rx_sync_r[1] == rx_sync_r[2]) rx_lvl_r <= rx_sync_r[2];
			rx_lvl_d_r <= rx_lvl_r;
		end
	end

	assign rx_tick = rx_st_r == RX_START ? rx_cyc_r == 16'(BIT_CYC / 2 - 1)
		: rx_cyc_r == 16'(BIT_CYC - 1);

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= RX_IDLE;
			rx_cyc_r <= 16'h0000;
			rx_bits_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_bad_r <= 1'h0;
		end else begin
			rx_cyc_r <= (rx_tick || rx_st_r == RX_IDLE) ? 16'h0000 :
				rx_cyc_r + 16'h0001;
			unique case (rx_st_r)
			RX_IDLE: begin
				rx_bits_r <= 4'h0;
				rx_bad_r <= 1'h0;
				if (!rx_lvl_r) rx_st_r <= RX_START;
			end
			RX_START: if (rx_tick) rx_st_r <= rx_lvl_r ? RX_IDLE : RX_DATA;
			RX_DATA: if (rx_tick) begin
				rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
				rx_bits_r <= rx_bits_r + 4'h1;
				if (rx_bits_r == 4'h7) rx_st_r <= RX_STOP1;
			end
			RX_STOP1: if (rx_tick) begin
				rx_bad_r <= !rx_lvl_r;
				// only select 2 with check mode 0 checks the second stop
				if (ctrl_r[1:0] == 2'h2 && !ctrl_r[uart_pkg::C_STOP_CHK])
					rx_st_r <= RX_STOP2;
				else rx_st_r <= RX_IDLE;
			end
			RX_STOP2: if (rx_tick) begin
				rx_bad_r <= rx_bad_r || !rx_lvl_r;
				rx_st_r <= RX_IDLE;
			end
			endcase
		end
	end

	assign rx_done = rx_tick &&
		(rx_st_r == RX_STOP2 || (rx_st_r == RX_STOP1 &&
		!(ctrl_r[1:0] == 2'h2 && !ctrl_r[uart_pkg::C_STOP_CHK])));

	// receive buffer and error flags; setting wins over clearing
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_r <= 8'h00;
			rx_full_r <= 1'h0;
			frame_err_r <= 1'h0;
			overrun_r <= 1'h0;
		end else begin
			if (rd_rx) rx_full_r <= 1'h0;
			if (wr_in && addr_in == uart_pkg::OFS_STATH) begin
				if (wdata_in[uart_pkg::S_FRAME_ERR]) frame_err_r <= 1'h0;
				if (wdata_in[uart_pkg::S_OVERRUN]) overrun_r <= 1'h0;
			end
			if (rx_done) begin
				if (rx_full_r && !rd_rx) begin
					overrun_r <= 1'h1;
				end else begin
					rx_data_r <= rx_sh_r;
					rx_full_r <= 1'h1;
					frame_err_r <= rx_bad_r || !rx_lvl_r ||
						frame_err_r;
				end
			end
		end
	end

	// wake from sleep on a start edge
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) wake_r <= 1'h0;
		else wake_r <= sleep_in && rx_st_r == RX_IDLE && rx_lvl_d_r &&
			!rx_lvl_r && ctrl_r[uart_pkg::C_WAKE] &&
			ctrl_r[uart_pkg::C_SLEEP_EN];
	end
	assign wake_out = wake_r;

	always_comb begin
		irq_set = 5'h00;
		irq_set[uart_pkg::I_RX] = rx_done && !(rx_full_r && !rd_rx);
		irq_set[uart_pkg::I_FRAME] = rx_done && !(rx_full_r && !rd_rx) &&
			(rx_bad_r || !rx_lvl_r);
		irq_set[uart_pkg::I_OVERRUN] = rx_done && rx_full_r && !rd_rx;
		irq_set[uart_pkg::I_WAIT] = tx_done && tx_last_r &&
			ctrl_r[uart_pkg::C_T1];
		irq_set[uart_pkg::I_WAKE] = wake_r;
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_r <= uart_pkg::IRQ_RST;
			irq_en_r <= uart_pkg::IRQ_RST;
		end else begin
			if (wr_in && addr_in == uart_pkg::OFS_IRQ_EN)
				irq_en_r <= wdata_in[4:0];
			if (wr_in && addr_in == uart_pkg::OFS_IRQ_CLR)
				irq_stat_r <= (irq_stat_r & ~wdata_in[4:0]) | irq_set;
			else
				irq_stat_r <= irq_stat_r | irq_set;
		end
	end
	assign irq_out = |(irq_stat_r & irq_en_r);

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			unique case (addr_in)
			uart_pkg::OFS_CTRL: rdata_out <= {7'h00, ctrl_r};
			uart_pkg::OFS_PARAM1: rdata_out <= {8'h00, tx_buf_r};
			uart_pkg::OFS_RXDATA: rdata_out <= {8'h00, rx_data_r};
			uart_pkg::OFS_STATH: rdata_out <= {8'h00, tx_wr_err_r, 3'h0,
				overrun_r, frame_err_r,
				tx_st_r != TX_IDLE || tx_pend_r, rx_full_r};
			uart_pkg::OFS_IRQ_STAT: rdata_out <= {11'h000, irq_stat_r};
			uart_pkg::OFS_IRQ_EN: rdata_out <= {11'h000, irq_en_r};
			default: rdata_out <= 16'h0000;
			endcase
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	a_two_stop_tx: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		tx_st_r == TX_STOP && tx_tick && tx_bits_r == 4'h0 &&
		ctrl_r[1] |=> tx_st_r == TX_STOP)
		else $error("second stop bit not sent");
	a_one_stop_chk: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		ctrl_r[1:0] == 2'h3 |-> rx_st_r != RX_STOP2)
		else $error("second stop checked in mode 3");
	a_framing_error_flag_second: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		rx_st_r == RX_STOP2 && rx_tick && !rx_lvl_r && !rx_full_r
		|=> frame_err_r)
		else $error("bad second stop not flagged");
	a_overrun_keep: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		rx_done && rx_full_r && !rd_rx |=> overrun_r &&
		rx_data_r == $past(rx_data_r))
		else $error("overrun not handled");
	a_wr_err_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		wr_in && addr_in == uart_pkg::OFS_STATH &&
		wdata_in[uart_pkg::S_TX_WR_ERR] |=> !tx_wr_err_r)
		else $error("write error flag not cleared");
	a_break_first: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		wr_param && !tx_pend_r && brk_req && ctrl_r[uart_pkg::C_ADDR] &&
		tx_st_r == TX_IDLE |=> ##1 tx_st_r == TX_BRK)
		else $error("break not started");
	a_break_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		$fell(brk_req) |-> $past(tx_st_r) == TX_BRK &&
		tx_st_r == TX_MARK)
		else $error("break bit cleared early");
	a_wait_last: assert property (@(posedge core_clk_in) disable iff (!rst_n)
		$rose(irq_stat_r[uart_pkg::I_WAIT]) |-> $past(tx_last_r) &&
		$past(ctrl_r[uart_pkg::C_T1]) && $past(tx_st_r) == TX_STOP)
		else $error("wait time without last char");
	c_break: cover property (@(posedge core_clk_in) disable iff (!rst_n)
		tx_st_r == TX_MARK ##1 tx_st_r == TX_MARK);
	c_overrun: cover property (@(posedge core_clk_in) disable iff (!rst_n)
		$rose(overrun_r));
	c_wake: cover property (@(posedge core_clk_in) disable iff (!rst_n)
		wake_r);
endmodule

// File: verif/far_serial.sv
`timescale 1ns/100ps
module far_serial #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic line_out
);
	logic [8:0] rq[$];
	int tq[$];
	int cyc = 0;
	logic [7:0] sh;
	initial line_out = 1'h1;
	// counted off the falling edge so timestamps never race the line
	always @(negedge clk_in) cyc <= cyc + 1;
	// remote sender, second stop can be pulled low
	task automatic send(input logic [7:0] b, input bit bad);
		@(posedge clk_in);
		line_out <= 1'h0;
		repeat (BIT_CYC) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			line_out <= b[i];
			repeat (BIT_CYC) @(posedge clk_in);
		end
		line_out <= 1'h1;
		repeat (BIT_CYC) @(posedge clk_in);
		line_out <= !bad;
		repeat (BIT_CYC) @(posedge clk_in);
		line_out <= 1'h1;
	endtask
	// remote receiver, low stop sample logged as break
	initial forever begin
		@(negedge line_in);
		tq.push_back(cyc);
		repeat (BIT_CYC / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk_in);
			sh[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge clk_in);
		if (line_in) begin
			rq.push_back({1'b0, sh});
		end else begin
			rq.push_back(9'h100);
			wait (line_in);
		end
	end
endmodule

// File: verif/tb.sv
`timescale 1ns/100ps
module tb;
	localparam int BC = 8;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic sleep = 1'h0;
	logic [15:0] rdata;
	logic txd;
	logic rxd;
	logic wake;
	logic irq;
	logic [15:0] v;
	logic [7:0] b[3];
	int fails = 0;
	int num_checks = 0;
	int cyc = 0;
	int wk = 0;
	always #25 clk = ~clk;
	uart_stop_break_wake #(.BIT_CYC(BC), .BRK_BITS(13)) u_dut (
		.core_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.rxd_in(rxd), .txd_out(txd), .sleep_in(sleep),
		.wake_out(wake), .irq_out(irq));
	far_serial #(.BIT_CYC(BC)) u_far (
		.clk_in(clk), .line_in(txd), .line_out(rxd));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake === 1'h1) wk++;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rdr(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 v = rdata;
	endtask
	task automatic waitq(input int n);
		for (int i = 0; i < 4000 && u_far.rq.size() < n; i++) @(posedge clk);
	endtask
	task automatic clean();
		repeat (12 * BC) @(posedge clk);
		rdr(uart_pkg::OFS_RXDATA);
		wrr(uart_pkg::OFS_STATH, 16'h008C);
		wrr(uart_pkg::OFS_IRQ_CLR, 16'h001F);
		u_far.rq.delete();
		u_far.tq.delete();
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(30));
		repeat (6) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		rdr(uart_pkg::OFS_CTRL);
		chk(v, {7'h00, uart_pkg::CTRL_RST});
		rdr(uart_pkg::OFS_IRQ_EN);
		chk(v, 16'h0000);
		rdr(uart_pkg::OFS_IRQ_CLR);
		chk(v, 16'h0000);
		chk(16'({txd, irq}), 16'h0002);
		$display("reset test done");
		for (int s = 0; s < 4; s++) begin
			for (int i = 0; i < 2; i++) b[i] = 8'($urandom);
			if (s == 3) b[0] = 8'h00;
			wrr(uart_pkg::OFS_CTRL, 16'(s));
			wrr(uart_pkg::OFS_TXDATA, {8'h00, b[0]});
			repeat (4) @(posedge clk);
			wrr(uart_pkg::OFS_TXDATA, {8'h00, b[1]});
			waitq(2);
			chk(16'(u_far.rq[1]), {8'h00, b[1]});
			// one idle clock between back-to-back characters
			v = 16'((s > 1 ? 11 : 10) * BC + 1);
			chk(16'(u_far.tq[1] - u_far.tq[0]), v);
			clean();
		end
		$display("stop send test done");
		for (int k = 0; k < 3; k++) begin
			b[0] = 8'($urandom);
			wrr(uart_pkg::OFS_CTRL, (k == 2) ? 16'h0003 : 16'h0002);
			u_far.send(b[0], k != 0);
			repeat (2 * BC) @(posedge clk);
			rdr(uart_pkg::OFS_STATH);
			chk(16'(v[uart_pkg::S_FRAME_ERR]), 16'(k == 1));
			rdr(uart_pkg::OFS_RXDATA);
			chk(v, {8'h00, b[0]});
			clean();
		end
		$display("stop check test done");
		wrr(uart_pkg::OFS_CTRL, 16'h0000);
		wrr(uart_pkg::OFS_IRQ_EN, 16'h0004);
		b[0] = 8'($urandom);
		u_far.send(b[0], 1'h0);
		chk(16'(irq), 16'h0000);
		u_far.send(~b[0], 1'h0);
		repeat (2 * BC) @(posedge clk);
		chk(16'(irq), 16'h0001);
		rdr(uart_pkg::OFS_STATH);
		chk(v & 16'h0009, 16'h0009);
		rdr(uart_pkg::OFS_RXDATA);
		chk(v, {8'h00, b[0]});
		rdr(uart_pkg::OFS_STATH);
		chk(16'(v[uart_pkg::S_RXFULL]), 16'h0000);
		wrr(uart_pkg::OFS_IRQ_CLR, 16'h0004);
		#1 chk(16'(irq), 16'h0000);
		clean();
		$display("overrun test done");
		for (int i = 0; i < 3; i++) b[i] = 8'($urandom);
		wrr(uart_pkg::OFS_TXDATA, {8'h00, b[0]});
		repeat (4) @(posedge clk);
		wrr(uart_pkg::OFS_TXDATA, {8'h00, b[1]});
		wrr(uart_pkg::OFS_TXDATA, {8'h00, b[2]});
		rdr(uart_pkg::OFS_STATH);
		chk(16'(v[uart_pkg::S_TX_WR_ERR]), 16'h0001);
		wrr(uart_pkg::OFS_STATH, 16'h0080);
		rdr(uart_pkg::OFS_STATH);
		chk(16'(v[uart_pkg::S_TX_WR_ERR]), 16'h0000);
		waitq(2);
		repeat (12 * BC) @(posedge clk);
		chk(16'(u_far.rq.size()), 16'h0002);
		clean();
		$display("write error test done");
		b[0] = 8'($urandom);
		wrr(uart_pkg::OFS_CTRL, 16'h0108);
		wrr(uart_pkg::OFS_PARAM1, {8'h00, b[0]});
		rdr(uart_pkg::OFS_CTRL);
		chk(16'(v[uart_pkg::C_BRK]), 16'h0001);
		waitq(2);
		chk(16'(u_far.rq[0]), 16'h0100);
		chk(16'(u_far.rq[1]), {8'h00, b[0]});
		rdr(uart_pkg::OFS_CTRL);
		chk(16'(v[uart_pkg::C_BRK]), 16'h0000);
		clean();
		$display("break test done");
		for (int k = 0; k < 2; k++) begin
			wrr(uart_pkg::OFS_CTRL, k ? 16'h00C0 : 16'h0040);
			wrr(uart_pkg::OFS_TXDATA, 16'h00A5);
			waitq(1);
			repeat (2 * BC) @(posedge clk);
			rdr(uart_pkg::OFS_IRQ_STAT);
			chk(16'(v[uart_pkg::I_WAIT]), 16'(k));
			clean();
		end
		$display("wait time test done");
		sleep <= 1'h1;
		for (int k = 0; k < 2; k++) begin
			wrr(uart_pkg::OFS_CTRL, k ? 16'h0030 : 16'h0010);
			wk = 0;
			u_far.send(8'h5A, 1'h0);
			chk(16'(wk), 16'(k));
			clean();
		end
		sleep <= 1'h0;
		$display("wake test done");
		wrap_up();
	end
endmodule
